// ### hw/exc_map.svh
// Vector numbers, module stop reset values and mode codes of the exception unit
`ifndef EXC_MAP_SVH
`define EXC_MAP_SVH

`define VEC_RESET       7'h00
`define VEC_TRACE       7'h05
`define VEC_DIRECT      7'h06
`define VEC_NMI         7'h07
`define VEC_TRAP_BASE   7'h08
`define VEC_EXT_FIRST   7'h10
`define VEC_EXT_LAST    7'h15
`define VEC_INT_FIRST   7'h18
`define VEC_INT_LAST    7'h7F

`define MSTP_A_RST      8'h3F
`define MSTP_B_RST      8'hFF
`define MSTP_C_RST      8'hFF

`define MODE_0          2'h0
`define MODE_2          2'h2

`define RST_HOLD_PWR_MS     20
`define RST_HOLD_RUN_STATES 20

`endif

// ### hw/exc_pkg.sv
// Types shared by the exception unit and its pin synchroniser
package exc_pkg;

    typedef enum logic [3:0] {
        ST_HOLD  = 4'h1,
        ST_INIT  = 4'h2,
        ST_FETCH = 4'h4,
        ST_RUN   = 4'h8
    } cpu_st_e;

    typedef enum logic [4:0] {
        EXC_NONE   = 5'h00,
        EXC_RESET  = 5'h01,
        EXC_TRACE  = 5'h02,
        EXC_DIRECT = 5'h04,
        EXC_IRQ    = 5'h08,
        EXC_TRAP   = 5'h10
    } exc_kind_e;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } sync_s;

    typedef struct packed {
        cpu_st_e   st;
        logic [1:0] mode;
        logic [7:0] mstp_a;
        logic [7:0] mstp_b;
        logic [7:0] mstp_c;
        logic      irq_block;
        logic      take;
        exc_kind_e kind;
        logic [6:0] vec_num;
        logic [15:0] vec_addr;
        logic      load_pc;
        logic      push_ctx;
        logic      set_cond_mask;
        logic      set_ext_mask;
        logic      clr_trace;
        logic      halt;
        logic      access_ok;
    } unit_s;

endpackage : exc_pkg

// ### hw/exception_priority_vector_unit.sv
// Exception priority, reset sequencing and vector generation for the CPU core
//
// Overview of operation
// - Order: reset, trace, direct, interrupt, trap.
// - Reset handling starts on pin rise or watchdog.
// - Pin low halts everything in reset state.
// - Trace at boundary when flag set, mode 2.
// - No trace after exception return instruction.
// - Sleep direct transition starts its exception.
// - Pending interrupt taken at instruction boundary.
// - No interrupt after mask ops, control load, reset.
// - Trap instruction taken at boundary unless a higher source is taken.
// - Each source has its own vector number.
// - Vector address is number times four or two.
// - Manual reset, direct, reserved vectors unavailable.
// - Reset init clears trace, sets both masks.
// - Reset then fetches vector zero into program counter.
// - Interrupt control mode is 0 after reset.
// - First instruction after reset runs before interrupts.
// - Module stop registers reset to 3F, FF, FF.
// - Stopped modules ignore register reads and writes.
// - Mode code 00 is mode 0, 10 mode 2.
// - Interrupt, trap push context, mask; interrupt clears trace, trap in mode 2 only.
// - Trap number 0 to 3 picks the vector.
`timescale 1ns/1ns
`include "exc_map.svh"
module exception_priority_vector_unit
    import exc_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        chip_init_pin_n,
    input  wire logic        wdt_overflow,
    input  wire logic        adv_mode,
    input  wire logic        trace_bit,
    input  wire logic        instr_end,
    input  wire logic        return_done,
    input  wire logic        mask_op_done,
    input  wire logic        sleep_direct,
    input  wire logic        trap_exec,
    input  wire logic [1:0]  trap_num,
    input  wire logic        irq_req,
    input  wire logic [6:0]  irq_vec,
    input  wire logic        mode_wr,
    input  wire logic [1:0]  mode_wdata,
    input  wire logic [2:0]  mstp_wr,
    input  wire logic [7:0]  mstp_wdata,
    input  wire logic        periph_req,
    input  wire logic [4:0]  periph_idx,
    output logic             cpu_halt,
    output logic             exc_take,
    output logic [4:0]       exc_kind,
    output logic [6:0]       vec_num,
    output logic [15:0]      vec_addr,
    output logic             load_pc,
    output logic             push_ctx,
    output logic             set_cond_mask,
    output logic             set_ext_mask,
    output logic             clr_trace,
    output logic [1:0]       int_ctrl_mode,
    output logic [7:0]       module_stop_ctrl_a,
    output logic [7:0]       module_stop_ctrl_b,
    output logic [7:0]       module_stop_ctrl_c,
    output logic             periph_access_ok
);

    unit_s       cur_ff;
    unit_s       nxt_ff;
    logic        pin_lvl;
    logic        trace_ok;
    logic        irq_ok;
    logic        vec_ok;
    logic [23:0] stop_bits;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser

    pin_sync3 u_pin_sync (
        .mclk   (mclk),
        .rst    (rst),
        .pin_in (chip_init_pin_n),
        .level  (pin_lvl)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Request qualification

    function automatic logic [15:0] vec_addr_f(input logic adv, input logic [6:0] num);
        vec_addr_f = adv ? {7'h00, num, 2'h0} : {8'h00, num, 1'h0};
    endfunction : vec_addr_f

    always_comb begin
        vec_ok = (irq_vec == `VEC_NMI)
            || ((irq_vec >= `VEC_EXT_FIRST) && (irq_vec <= `VEC_EXT_LAST))
            || (irq_vec >= `VEC_INT_FIRST);
        trace_ok = trace_bit && (cur_ff.mode == `MODE_2) && !return_done;
        irq_ok = irq_req && vec_ok && !mask_op_done && !cur_ff.irq_block;
    end

    assign stop_bits = {cur_ff.mstp_c, cur_ff.mstp_b, cur_ff.mstp_a};

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        nxt_ff               = cur_ff;
        nxt_ff.take          = 1'b0;
        nxt_ff.load_pc       = 1'b0;
        nxt_ff.push_ctx      = 1'b0;
        nxt_ff.set_cond_mask = 1'b0;
        nxt_ff.set_ext_mask  = 1'b0;
        nxt_ff.clr_trace     = 1'b0;
        nxt_ff.access_ok     = periph_req && (periph_idx < 5'h18)
            && !stop_bits[periph_idx];
        if (mode_wr && ((mode_wdata == `MODE_0) || (mode_wdata == `MODE_2))) begin
            nxt_ff.mode = mode_wdata;
        end
        if (mstp_wr[0]) begin
            nxt_ff.mstp_a = mstp_wdata;
        end
        if (mstp_wr[1]) begin
            nxt_ff.mstp_b = mstp_wdata;
        end
        if (mstp_wr[2]) begin
            nxt_ff.mstp_c = mstp_wdata;
        end
        case (cur_ff.st)
            ST_HOLD: begin
                nxt_ff.halt = 1'b1;
                if (pin_lvl) begin
                    nxt_ff.st = ST_INIT;
                end
            end
            ST_INIT: begin
                nxt_ff.clr_trace     = 1'b1;
                nxt_ff.set_cond_mask = 1'b1;
                nxt_ff.set_ext_mask  = 1'b1;
                nxt_ff.mode          = `MODE_0;
                nxt_ff.mstp_a        = `MSTP_A_RST;
                nxt_ff.mstp_b        = `MSTP_B_RST;
                nxt_ff.mstp_c        = `MSTP_C_RST;
                nxt_ff.st            = ST_FETCH;
            end
            ST_FETCH: begin
                nxt_ff.take      = 1'b1;
                nxt_ff.kind      = EXC_RESET;
                nxt_ff.vec_num   = `VEC_RESET;
                nxt_ff.vec_addr  = vec_addr_f(adv_mode, `VEC_RESET);
                nxt_ff.load_pc   = 1'b1;
                nxt_ff.irq_block = 1'b1;
                nxt_ff.halt      = 1'b0;
                nxt_ff.st        = ST_RUN;
            end
            ST_RUN: begin
                if (wdt_overflow) begin
                    nxt_ff.halt = 1'b1;
                    nxt_ff.st   = ST_INIT;
                end else if (instr_end) begin
                    nxt_ff.irq_block = 1'b0;
                    if (trace_ok) begin
                        nxt_ff.take          = 1'b1;
                        nxt_ff.kind          = EXC_TRACE;
                        nxt_ff.vec_num       = `VEC_TRACE;
                        nxt_ff.vec_addr      = vec_addr_f(adv_mode, `VEC_TRACE);
                        nxt_ff.load_pc       = 1'b1;
                        nxt_ff.push_ctx      = 1'b1;
                        nxt_ff.set_cond_mask = 1'b1;
                        nxt_ff.clr_trace     = 1'b1;
                    end else if (sleep_direct) begin
                        // Only the vector number is set for this event, no address, so no fetch
                        nxt_ff.take    = 1'b1;
                        nxt_ff.kind    = EXC_DIRECT;
                        nxt_ff.vec_num = `VEC_DIRECT;
                    end else if (irq_ok) begin
                        nxt_ff.take          = 1'b1;
                        nxt_ff.kind          = EXC_IRQ;
                        nxt_ff.vec_num       = irq_vec;
                        nxt_ff.vec_addr      = vec_addr_f(adv_mode, irq_vec);
                        nxt_ff.load_pc       = 1'b1;
                        nxt_ff.push_ctx      = 1'b1;
                        nxt_ff.set_cond_mask = 1'b1;
                        nxt_ff.clr_trace     = 1'b1;
                    end else if (trap_exec) begin
                        nxt_ff.take          = 1'b1;
                        nxt_ff.kind          = EXC_TRAP;
                        nxt_ff.vec_num       = `VEC_TRAP_BASE + {5'h00, trap_num};
                        nxt_ff.vec_addr      = vec_addr_f(adv_mode,
                            `VEC_TRAP_BASE + {5'h00, trap_num});
                        nxt_ff.load_pc       = 1'b1;
                        nxt_ff.push_ctx      = 1'b1;
                        nxt_ff.set_cond_mask = 1'b1;
                        nxt_ff.clr_trace     = (cur_ff.mode == `MODE_2);
                    end
                end
            end
            default: begin
                nxt_ff.st = ST_HOLD;
            end
        endcase
        if (!pin_lvl) begin
            nxt_ff.st        = ST_HOLD;
            nxt_ff.halt      = 1'b1;
            nxt_ff.take      = 1'b0;
            nxt_ff.load_pc   = 1'b0;
            nxt_ff.push_ctx  = 1'b0;
            nxt_ff.access_ok = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cur_ff           <= '0;
            cur_ff.st        <= ST_HOLD;
            cur_ff.kind      <= EXC_NONE;
            cur_ff.halt      <= 1'b1;
            cur_ff.irq_block <= 1'b1;
            cur_ff.mstp_a    <= `MSTP_A_RST;
            cur_ff.mstp_b    <= `MSTP_B_RST;
            cur_ff.mstp_c    <= `MSTP_C_RST;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign cpu_halt           = cur_ff.halt;
    assign exc_take           = cur_ff.take;
    assign exc_kind           = cur_ff.kind;
    assign vec_num            = cur_ff.vec_num;
    assign vec_addr           = cur_ff.vec_addr;
    assign load_pc            = cur_ff.load_pc;
    assign push_ctx           = cur_ff.push_ctx;
    assign set_cond_mask      = cur_ff.set_cond_mask;
    assign set_ext_mask       = cur_ff.set_ext_mask;
    assign clr_trace          = cur_ff.clr_trace;
    assign int_ctrl_mode      = cur_ff.mode;
    assign module_stop_ctrl_a = cur_ff.mstp_a;
    assign module_stop_ctrl_b = cur_ff.mstp_b;
    assign module_stop_ctrl_c = cur_ff.mstp_c;
    assign periph_access_ok   = cur_ff.access_ok;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    property p_prio;
        @(posedge mclk) disable iff (rst)
        (cur_ff.st == ST_RUN && pin_lvl && !wdt_overflow && instr_end && trace_ok)
        |=> (exc_take && exc_kind == EXC_TRACE);
    endproperty
    a_prio: assert property (p_prio) else $error("trace lost priority");

    property p_wdt;
        @(posedge mclk) disable iff (rst)
        (cur_ff.st == ST_RUN && pin_lvl && wdt_overflow)
        |=> (cur_ff.st == ST_INIT) ##1 (clr_trace && set_ext_mask) ##1
            (exc_take && exc_kind == EXC_RESET && vec_num == `VEC_RESET);
    endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog reset sequence wrong");

    property p_halt;
        @(posedge mclk) disable iff (rst)
        !pin_lvl |=> (cpu_halt && !exc_take) [*2];
    endproperty
    a_halt: assert property (p_halt) else $error("not halted with pin low");

    property p_no_trace_ret;
        @(posedge mclk) disable iff (rst)
        (instr_end && return_done) |=> !(exc_take && exc_kind == EXC_TRACE);
    endproperty
    a_no_trace_ret: assert property (p_no_trace_ret) else $error("trace after return");

    property p_mask_op;
        @(posedge mclk) disable iff (rst)
        (instr_end && mask_op_done) |=> !(exc_take && exc_kind == EXC_IRQ);
    endproperty
    a_mask_op: assert property (p_mask_op) else $error("irq after mask op");

    property p_first_instr;
        @(posedge mclk) disable iff (rst)
        (exc_take && exc_kind == EXC_RESET) |-> ##1 !(exc_take && exc_kind == EXC_IRQ);
    endproperty
    a_first_instr: assert property (p_first_instr) else $error("irq before first");

    property p_addr;
        @(posedge mclk) disable iff (rst)
        (exc_take && load_pc) |-> vec_addr == ($past(adv_mode)
            ? {7'h00, vec_num, 2'h0} : {8'h00, vec_num, 1'h0});
    endproperty
    a_addr: assert property (p_addr) else $error("vector address wrong");

    property p_mstp;
        @(posedge mclk) disable iff (rst)
        (cur_ff.st == ST_INIT && pin_lvl) |=> (module_stop_ctrl_a == `MSTP_A_RST
            && module_stop_ctrl_b == `MSTP_B_RST && module_stop_ctrl_c == `MSTP_C_RST
            && int_ctrl_mode == `MODE_0);
    endproperty
    a_mstp: assert property (p_mstp) else $error("module stop init wrong");

    property p_stopped;
        @(posedge mclk) disable iff (rst)
        (periph_req && periph_idx < 5'h18 && stop_bits[periph_idx]) |=> !periph_access_ok;
    endproperty
    a_stopped: assert property (p_stopped) else $error("stopped module accessed");

    property p_mode_bad;
        @(posedge mclk) disable iff (rst)
        (cur_ff.st == ST_RUN && pin_lvl && !wdt_overflow && mode_wr && mode_wdata[0])
        |=> int_ctrl_mode == $past(int_ctrl_mode);
    endproperty
    a_mode_bad: assert property (p_mode_bad) else $error("prohibited mode taken");

    property p_trap_vec;
        @(posedge mclk) disable iff (rst)
        (exc_take && exc_kind == EXC_TRAP) |-> vec_num == `VEC_TRAP_BASE + {5'h00, $past(trap_num)};
    endproperty
    a_trap_vec: assert property (p_trap_vec) else $error("trap vector wrong");

    c_reset: cover property (@(posedge mclk) disable iff (rst)
        exc_take && exc_kind == EXC_RESET);
    c_irq: cover property (@(posedge mclk) disable iff (rst)
        exc_take && exc_kind == EXC_IRQ);
    c_trap: cover property (@(posedge mclk) disable iff (rst)
        exc_take && exc_kind == EXC_TRAP);
    c_trace: cover property (@(posedge mclk) disable iff (rst)
        exc_take && exc_kind == EXC_TRACE);

endmodule : exception_priority_vector_unit

// ### hw/pin_sync3.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module pin_sync3
    import exc_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic pin_in,
    output logic      level
);

    sync_s cur_ff;
    sync_s nxt_ff;

    always_comb begin
        nxt_ff    = cur_ff;
        nxt_ff.s1 = pin_in;
        nxt_ff.s2 = cur_ff.s1;
        nxt_ff.s3 = cur_ff.s2;
        if (cur_ff.s2 == cur_ff.s3) begin
            nxt_ff.lvl = cur_ff.s3;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    assign level = cur_ff.lvl;

endmodule : pin_sync3

// ### verification/core_partner.sv
// Far-side model: interrupt source of the controller and the chip reset pin driver
`timescale 1ns/1ns
module core_partner #(
    parameter int HOLD = 20
) (
    input  wire logic       mclk,
    input  wire logic       raise,
    input  wire logic       cancel,
    input  wire logic [6:0] vec_in,
    input  wire logic       pin_drop,
    input  wire logic       exc_take,
    input  wire logic [4:0] exc_kind,
    output logic            irq_req,
    output logic [6:0]      irq_vec,
    output logic            chip_init_pin_n
);
    int cnt_ff = 0;

    initial begin
        irq_req = 1'b0;
        irq_vec = 7'h00;
        chip_init_pin_n = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Request stays pending until accepted or cancelled; a lower source dropped at a boundary waits
    always @(posedge mclk) begin
        if (raise) begin
            irq_req <= 1'b1;
            irq_vec <= vec_in;
        end else if (cancel || (exc_take === 1'b1 && exc_kind === 5'h08)) begin
            irq_req <= 1'b0;
        end else if (!irq_req) begin
            irq_vec <= ~irq_vec;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin is held low for the full minimum number of states
    always @(posedge mclk) begin
        if (pin_drop) begin
            cnt_ff <= HOLD;
            chip_init_pin_n <= 1'b0;
        end else if (cnt_ff > 1) begin
            cnt_ff <= cnt_ff - 1;
        end else begin
            cnt_ff <= 0;
            chip_init_pin_n <= 1'b1;
        end
    end
endmodule : core_partner

// ### verification/testbench.sv
// Self-checking bench for the exception priority and vector unit
`timescale 1ns/1ns
`include "exc_map.svh"
module testbench;
    logic        mclk, rst, wdt_overflow, adv_mode, trace_bit, instr_end, return_done;
    logic        mask_op_done, sleep_direct, trap_exec, mode_wr, periph_req;
    logic        raise, cancel, pin_drop, chip_init_pin_n, irq_req;
    logic [1:0]  trap_num, mode_wdata, int_ctrl_mode;
    logic [2:0]  mstp_wr;
    logic [7:0]  mstp_wdata, module_stop_ctrl_a, module_stop_ctrl_b, module_stop_ctrl_c;
    logic [4:0]  periph_idx, exc_kind;
    logic [6:0]  vec_in, irq_vec, vec_num;
    logic [15:0] vec_addr;
    logic        cpu_halt, exc_take, load_pc, push_ctx, set_cond_mask, set_ext_mask;
    logic        clr_trace, periph_access_ok;
    int          fails = 0;
    int          n_compared = 0;
    logic [6:0]  good [6] = '{7'h07, 7'h10, 7'h15, 7'h18, 7'h40, 7'h7F};
    logic [6:0]  bad [8] = '{7'h01, 7'h02, 7'h04, 7'h06, 7'h0C, 7'h0F, 7'h16, 7'h17};

    exception_priority_vector_unit i_dut (
        .mclk(mclk), .rst(rst), .chip_init_pin_n(chip_init_pin_n),
        .wdt_overflow(wdt_overflow), .adv_mode(adv_mode), .trace_bit(trace_bit),
        .instr_end(instr_end), .return_done(return_done), .mask_op_done(mask_op_done),
        .sleep_direct(sleep_direct), .trap_exec(trap_exec), .trap_num(trap_num),
        .irq_req(irq_req), .irq_vec(irq_vec), .mode_wr(mode_wr), .mode_wdata(mode_wdata),
        .mstp_wr(mstp_wr), .mstp_wdata(mstp_wdata), .periph_req(periph_req),
        .periph_idx(periph_idx), .cpu_halt(cpu_halt), .exc_take(exc_take),
        .exc_kind(exc_kind), .vec_num(vec_num), .vec_addr(vec_addr), .load_pc(load_pc),
        .push_ctx(push_ctx), .set_cond_mask(set_cond_mask), .set_ext_mask(set_ext_mask),
        .clr_trace(clr_trace), .int_ctrl_mode(int_ctrl_mode),
        .module_stop_ctrl_a(module_stop_ctrl_a), .module_stop_ctrl_b(module_stop_ctrl_b),
        .module_stop_ctrl_c(module_stop_ctrl_c), .periph_access_ok(periph_access_ok));

    core_partner #(.HOLD(`RST_HOLD_RUN_STATES)) i_far (
        .mclk(mclk), .raise(raise), .cancel(cancel), .vec_in(vec_in), .pin_drop(pin_drop),
        .exc_take(exc_take), .exc_kind(exc_kind), .irq_req(irq_req), .irq_vec(irq_vec),
        .chip_init_pin_n(chip_init_pin_n));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic stop_test;
        $display("compared %0d, mismatched %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test

    // Qualifiers q: trace flag, return, mask op, sleep direct, trap
    task automatic bnd(input logic [4:0] q, input logic [1:0] tn);
        @(posedge mclk);
        instr_end <= 1'b1;
        {trace_bit, return_done, mask_op_done, sleep_direct, trap_exec} <= q;
        trap_num <= tn;
        @(posedge mclk);
        instr_end <= 1'b0;
        {trace_bit, return_done, mask_op_done, sleep_direct, trap_exec} <= 5'h00;
        #1;
    endtask : bnd

    task automatic take(input logic [4:0] k, input logic [6:0] v, input logic [15:0] a);
        chk(exc_take, 1'b1);
        chk(exc_kind, k);
        chk(vec_num, v);
        chk(vec_addr, a);
    endtask : take

    task automatic irq(input logic [6:0] v, input logic drop);
        @(posedge mclk);
        raise <= !drop;
        cancel <= drop;
        vec_in <= v;
        @(posedge mclk);
        raise <= 1'b0;
        cancel <= 1'b0;
    endtask : irq

    task automatic wr(input logic m, input logic [2:0] sel, input logic [7:0] d);
        @(posedge mclk);
        mode_wr <= m;
        mode_wdata <= d[1:0];
        mstp_wr <= sel;
        mstp_wdata <= d;
        @(posedge mclk);
        mode_wr <= 1'b0;
        mstp_wr <= 3'b000;
        #1;
    endtask : wr

    task automatic acc(input logic [4:0] idx, input logic exp);
        @(posedge mclk);
        periph_req <= 1'b1;
        periph_idx <= idx;
        @(posedge mclk);
        periph_req <= 1'b0;
        #1;
        chk(periph_access_ok, exp);
    endtask : acc

    task automatic wait_rst;
        logic seen;
        seen = 1'b0;
        for (int i = 0; i < 60 && exc_take !== 1'b1; i++) begin
            @(posedge mclk);
            #1;
            if (set_ext_mask === 1'b1) begin
                seen = 1'b1;
                chk({set_cond_mask, clr_trace}, 2'b11);
            end
        end
        chk(seen, 1'b1);
        take(5'h01, 7'h00, 16'h0000);
        chk({cpu_halt, load_pc, int_ctrl_mode}, 4'b0100);
        chk({module_stop_ctrl_a, module_stop_ctrl_b, module_stop_ctrl_c}, 24'h3FFFFF);
    endtask : wait_rst

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_first_irq(input logic [6:0] v);
        irq(v, 1'b0);
        bnd(5'h00, 2'd0);
        chk(exc_take, 1'b0);
        bnd(5'h04, 2'd0);
        chk(exc_take, 1'b0);
        bnd(5'h00, 2'd0);
        take(5'h08, v, {7'h00, v, 2'b00});
        chk({load_pc, push_ctx, set_cond_mask, set_ext_mask, clr_trace}, 5'b11101);
    endtask : t_first_irq

    task automatic t_vectors;
        for (int m = 0; m < 2; m++) begin
            @(posedge mclk);
            adv_mode <= m[0];
            foreach (good[i]) begin
                irq(good[i], 1'b0);
                bnd(5'h00, 2'd0);
                take(5'h08, good[i], m[0] ? {7'h00, good[i], 2'b00} : {8'h00, good[i], 1'b0});
            end
        end
        foreach (bad[i]) begin
            irq(bad[i], 1'b0);
            bnd(5'h00, 2'd0);
            chk(exc_take, 1'b0);
            irq(7'h00, 1'b1);
        end
        for (int n = 0; n < 4; n++) begin
            bnd(5'h01, n[1:0]);
            take(5'h10, 7'h08 + n[6:0], 16'h0020 + 16'(n * 4));
            chk(clr_trace, 1'b0);
        end
    endtask : t_vectors

    task automatic t_modes;
        bnd(5'h10, 2'd0);
        chk(exc_take, 1'b0);
        wr(1'b1, 3'b000, 8'h01);
        chk(int_ctrl_mode, 2'b00);
        wr(1'b1, 3'b000, 8'h02);
        chk(int_ctrl_mode, 2'b10);
        wr(1'b1, 3'b000, 8'h03);
        chk(int_ctrl_mode, 2'b10);
        bnd(5'h10, 2'd0);
        take(5'h02, 7'h05, 16'h0014);
        chk({push_ctx, set_cond_mask, clr_trace}, 3'b111);
        bnd(5'h18, 2'd0);
        chk(exc_take, 1'b0);
    endtask : t_modes

    task automatic t_priority;
        irq(7'h12, 1'b0);
        bnd(5'h13, 2'd1);
        take(5'h02, 7'h05, 16'h0014);
        bnd(5'h03, 2'd1);
        chk({exc_take, exc_kind, vec_num, load_pc, push_ctx}, {1'b1, 5'h04, 7'h06, 2'b00});
        bnd(5'h01, 2'd1);
        take(5'h08, 7'h12, 16'h0048);
        bnd(5'h01, 2'd3);
        take(5'h10, 7'h0B, 16'h002C);
        chk(clr_trace, 1'b1);
    endtask : t_priority

    task automatic t_stop;
        acc(5'd5, 1'b0);
        acc(5'd6, 1'b1);
        acc(5'd8, 1'b0);
        wr(1'b0, 3'b010, 8'hFE);
        acc(5'd8, 1'b1);
        acc(5'd9, 1'b0);
        wr(1'b0, 3'b001, 8'h00);
        acc(5'd5, 1'b1);
        wr(1'b0, 3'b100, 8'h7F);
        acc(5'd23, 1'b1);
        acc(5'd16, 1'b0);
        acc(5'd24, 1'b0);
    endtask : t_stop

    task automatic t_resets;
        @(posedge mclk);
        wdt_overflow <= 1'b1;
        @(posedge mclk);
        wdt_overflow <= 1'b0;
        wait_rst;
        t_first_irq(7'h13);
        @(posedge mclk);
        pin_drop <= 1'b1;
        @(posedge mclk);
        pin_drop <= 1'b0;
        repeat (8) @(posedge mclk);
        #1;
        chk(cpu_halt, 1'b1);
        bnd(5'h01, 2'd0);
        chk(exc_take, 1'b0);
        wait_rst;
    endtask : t_resets

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    initial begin
        #20000;
        fails++;
        stop_test();
    end

    initial begin
        rst = 1'b1;
        {wdt_overflow, trace_bit, instr_end, return_done, mask_op_done} = 5'h00;
        {sleep_direct, trap_exec, mode_wr, periph_req, raise, cancel, pin_drop} = 7'h00;
        adv_mode = 1'b1;
        trap_num = 2'd0;
        mode_wdata = 2'd0;
        mstp_wr = 3'd0;
        mstp_wdata = 8'h00;
        periph_idx = 5'd0;
        vec_in = 7'h00;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        wait_rst;
        t_first_irq(7'h10);
        t_vectors();
        t_modes();
        t_priority();
        t_stop();
        t_resets();
        stop_test();
    end
endmodule : testbench
